// *** inc/uart_rx_pkg.sv ***
package uart_rx_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_SERIAL_CTRL = 8'h00;
  localparam logic [7:0] OFF_POWER_CTRL = 8'h04;
  localparam logic [7:0] OFF_SLAVE_ADDR = 8'h08;
  localparam logic [7:0] OFF_SLAVE_MASK = 8'h0C;
  localparam logic [7:0] OFF_RX_BUF = 8'h10;
  localparam logic [7:0] OFF_TX_BUF = 8'h14;
  localparam logic [7:0] OFF_RX_DIV = 8'h18;
  localparam logic [7:0] OFF_TX_DIV = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;

  // serial_control_reg field positions
  localparam int CTRL_RI_BIT = 0;
  localparam int CTRL_TI_BIT = 1;
  localparam int CTRL_RB8_BIT = 2;
  localparam int CTRL_TB8_BIT = 3;
  localparam int CTRL_REN_BIT = 4;
  localparam int CTRL_MPE_BIT = 5;
  localparam int CTRL_MODE_LSB = 6;
  localparam int CTRL_FE_BIT = 8;
  // power_control_reg field position
  localparam int POWER_CONTROL_REG_FEE_BIT = 0;

  // interrupt status / mask bit positions
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;
  localparam int IRQ_FE_BIT = 2;
  localparam int IRQ_WIDTH = 3;

  // reset values
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0015;

  // oversampling timing counts (ticks per bit, sample points)
  localparam logic [3:0] SAMPLE_LAST = 4'hF;
  localparam logic [3:0] START_MID = 4'h7;
  localparam logic [3:0] BITS_SHORT = 4'h8;
  localparam logic [3:0] BITS_LONG = 4'h9;
  localparam logic [3:0] TX_BITS_SHORT = 4'hA;
  localparam logic [3:0] TX_BITS_LONG = 4'hB;

  // serial port operating modes
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_ASYNC8 = 2'h1;

  // receiver and transmitter states
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
    rx_state_type;
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_type;
endpackage : uart_rx_pkg

// *** hdl/pin_sync.sv ***
`timescale 1ns/1ps
// three-stage pin synchroniser with agreement filter
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pin and filtered level
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic s1; // first stage, read only by s2
    logic s2; // second stage
    logic s3; // third stage
    logic q; // filtered level
  } sync_state_type;

  sync_state_type r;
  sync_state_type next_r;

  // level changes only once the second and third stages agree
  always_comb begin
    next_r = r;
    next_r.s1 = pin;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (r.s2 == r.s3) begin
      next_r.q = r.s3;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= {4{RESET_LEVEL}};
    end else begin
      r <= next_r;
    end
  end

  assign level = r.q;
endmodule : pin_sync

// *** hdl/baud_tick.sv ***
`timescale 1ns/1ps
// oversampling tick generator: one pulse every divisor+1 clocks
module baud_tick #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // reload value and tick output
  input wire logic [WIDTH-1:0] divisor,
  output logic tick
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt; // down counter
    logic tick; // registered pulse
  } tick_state_type;

  tick_state_type r;
  tick_state_type next_r;

  if (WIDTH < 2) begin : g_check
    $error("baud_tick WIDTH must be at least 2");
  end

  // count down, pulse and reload at zero
  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.cnt == '0) begin
      next_r.cnt = divisor;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;
endmodule : baud_tick

// *** hdl/uart_rx_frame_error_addr_match.sv ***
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module uart_rx_frame_error_addr_match #(
  parameter int DIV_WIDTH = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  input wire logic rxd,
  output logic txd,
  // interrupt
  output logic irq
);
  if (DIV_WIDTH < 4 || DIV_WIDTH > 16) begin : g_check
    $error("DIV_WIDTH must lie between 4 and 16");
  end

  typedef struct packed {
    logic [1:0] mode; // serial mode
    logic mpe; // multiproc_enable
    logic ren; // receive enable
    logic tb8; // ninth bit to send
    logic rb8; // ninth bit received
    logic ti; // transmit done flag
    logic ri; // receive_done_flag
    logic fe; // framing_error_flag
    logic fee; // frame_error_enable
    logic [7:0] slave_address_reg; // slave_address_reg
    logic [7:0] smask; // slave_address_mask_reg
    logic [7:0] rxbuf; // received byte
    logic [DIV_WIDTH-1:0] rxdiv; // receive baud divisor
    logic [DIV_WIDTH-1:0] txdiv; // transmit baud divisor
    logic [2:0] ist; // sticky interrupt status
    logic [2:0] imask; // interrupt mask
    uart_rx_pkg::rx_state_type rxs; // receiver state
    logic [3:0] rxt; // receive tick count
    logic [3:0] rxn; // receive bit index
    logic [8:0] rxsh; // receive data bits
    uart_rx_pkg::tx_state_type txs; // transmitter state
    logic [3:0] txt; // transmit tick count
    logic [3:0] txn; // transmit bit index
    logic [10:0] txsh; // transmit shifter
    logic txd; // line output
    logic irq; // interrupt output
    logic pready; // bus ready
    logic pslverr; // bus error
    logic [31:0] prdata; // read data
  } state_type;

  state_type r;
  state_type next_r;
  logic rx_level; // synchronised receive line
  logic rx_tick; // receive oversampling tick
  logic tx_tick; // transmit oversampling tick

  // receive line synchroniser
  pin_sync #(.RESET_LEVEL(1'b1)) u_rx_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(rxd),
    .level(rx_level)
  );

  // independent baud ticks for each direction
  baud_tick #(.WIDTH(DIV_WIDTH)) u_rx_tick (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(r.rxdiv),
    .tick(rx_tick)
  );

  baud_tick #(.WIDTH(DIV_WIDTH)) u_tx_tick (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(r.txdiv),
    .tick(tx_tick)
  );

  // all next-state logic
  always_comb begin
    logic setup; // setup phase of a transfer
    logic wr; // write takes effect now
    logic mapped; // address decodes
    logic [31:0] rd; // read mux value
    logic [8:0] word; // frame bits incl. current sample
    logic [3:0] nbits; // data bits in this mode
    logic fin; // frame ready for decision
    logic ninth; // ninth bit or stop bit
    logic given_hit; // given address matches
    logic bcast_hit; // broadcast address matches
    logic [7:0] bcast; // broadcast address
    logic async_mode; // modes 1, 2, 3
    logic filt; // address filtering active
    logic accept; // frame is delivered
    setup = psel && !penable;
    wr = psel && penable && r.pready && pwrite;
    mapped = 1'b1;
    rd = '0;
    word = r.rxsh;
    nbits = uart_rx_pkg::BITS_SHORT;
    fin = 1'b0;
    ninth = 1'b0;
    given_hit = 1'b0;
    bcast_hit = 1'b0;
    bcast = '0;
    async_mode = r.mode != uart_rx_pkg::MODE_SHIFT;
    filt = 1'b0;
    accept = 1'b0;
    next_r = r;

    // read mux and decode
    case (paddr)
      uart_rx_pkg::OFF_SERIAL_CTRL: begin
        rd[uart_rx_pkg::CTRL_RI_BIT] = r.ri;
        rd[uart_rx_pkg::CTRL_TI_BIT] = r.ti;
        rd[uart_rx_pkg::CTRL_RB8_BIT] = r.rb8;
        rd[uart_rx_pkg::CTRL_TB8_BIT] = r.tb8;
        rd[uart_rx_pkg::CTRL_REN_BIT] = r.ren;
        rd[uart_rx_pkg::CTRL_MPE_BIT] = r.mpe;
        rd[uart_rx_pkg::CTRL_MODE_LSB +: 2] = r.mode;
        rd[uart_rx_pkg::CTRL_FE_BIT] = r.fe;
      end
      uart_rx_pkg::OFF_POWER_CTRL: rd[uart_rx_pkg::POWER_CONTROL_REG_FEE_BIT] = r.fee;
      uart_rx_pkg::OFF_SLAVE_ADDR: rd[7:0] = r.slave_address_reg;
      uart_rx_pkg::OFF_SLAVE_MASK: rd[7:0] = r.smask;
      uart_rx_pkg::OFF_RX_BUF: rd[7:0] = r.rxbuf;
      uart_rx_pkg::OFF_TX_BUF: rd = '0;
      uart_rx_pkg::OFF_RX_DIV: rd[DIV_WIDTH-1:0] = r.rxdiv;
      uart_rx_pkg::OFF_TX_DIV: rd[DIV_WIDTH-1:0] = r.txdiv;
      uart_rx_pkg::OFF_IRQ_STATUS: rd[2:0] = r.ist;
      uart_rx_pkg::OFF_IRQ_MASK: rd[2:0] = r.imask;
      default: mapped = 1'b0;
    endcase

    // zero-wait answer: ready in the access phase
    next_r.pready = setup;
    next_r.pslverr = setup && !mapped;
    next_r.prdata = (setup && !pwrite) ? rd : '0;

    // software writes first, so hardware sets below win
    if (wr) begin
      case (paddr)
        uart_rx_pkg::OFF_SERIAL_CTRL: begin
          next_r.ri = pwdata[uart_rx_pkg::CTRL_RI_BIT];
          next_r.ti = pwdata[uart_rx_pkg::CTRL_TI_BIT];
          next_r.rb8 = pwdata[uart_rx_pkg::CTRL_RB8_BIT];
          next_r.tb8 = pwdata[uart_rx_pkg::CTRL_TB8_BIT];
          next_r.ren = pwdata[uart_rx_pkg::CTRL_REN_BIT];
          next_r.mpe = pwdata[uart_rx_pkg::CTRL_MPE_BIT];
          next_r.mode = pwdata[uart_rx_pkg::CTRL_MODE_LSB +: 2];
          next_r.fe = pwdata[uart_rx_pkg::CTRL_FE_BIT];
        end
        uart_rx_pkg::OFF_POWER_CTRL: begin
          next_r.fee = pwdata[uart_rx_pkg::POWER_CONTROL_REG_FEE_BIT];
        end
        uart_rx_pkg::OFF_SLAVE_ADDR: next_r.slave_address_reg = pwdata[7:0];
        uart_rx_pkg::OFF_SLAVE_MASK: next_r.smask = pwdata[7:0];
        uart_rx_pkg::OFF_TX_BUF: begin
          // start a frame; writes while busy are dropped
          if (r.txs == uart_rx_pkg::TX_IDLE) begin
            next_r.txs = uart_rx_pkg::TX_SEND;
            next_r.txt = '0;
            next_r.txn = '0;
            next_r.txsh = {1'b1, (r.mode[1] ? r.tb8 : 1'b1),
                           pwdata[7:0], 1'b0};
          end
        end
        uart_rx_pkg::OFF_RX_DIV: next_r.rxdiv = pwdata[DIV_WIDTH-1:0];
        uart_rx_pkg::OFF_TX_DIV: next_r.txdiv = pwdata[DIV_WIDTH-1:0];
        uart_rx_pkg::OFF_IRQ_STATUS: next_r.ist = r.ist & ~pwdata[2:0];
        uart_rx_pkg::OFF_IRQ_MASK: next_r.imask = pwdata[2:0];
        default: next_r.ist = next_r.ist;
      endcase
    end

    // modes 2 and 3 carry a ninth data bit
    if (r.mode[1]) begin
      nbits = uart_rx_pkg::BITS_LONG;
    end
    word[r.rxn] = rx_level;
    filt = async_mode && r.mpe;

    // receiver state machine, 16 ticks per bit
    case (r.rxs)
      uart_rx_pkg::RX_IDLE: begin
        next_r.rxt = '0;
        next_r.rxn = '0;
        if (r.ren && !async_mode && !r.ri) begin
          // shift mode: no start bit, no checks
          next_r.rxs = uart_rx_pkg::RX_DATA;
        end else if (r.ren && async_mode && !rx_level) begin
          next_r.rxs = uart_rx_pkg::RX_START;
        end
      end
      uart_rx_pkg::RX_START: begin
        if (rx_tick) begin
          next_r.rxt = r.rxt + 1'b1;
          if (r.rxt == uart_rx_pkg::START_MID) begin
            // false start rejected at the middle of the bit
            next_r.rxt = '0;
            next_r.rxs = rx_level ? uart_rx_pkg::RX_IDLE
                                  : uart_rx_pkg::RX_DATA;
          end
        end
      end
      uart_rx_pkg::RX_DATA: begin
        if (rx_tick) begin
          next_r.rxt = r.rxt + 1'b1;
          if (r.rxt == uart_rx_pkg::SAMPLE_LAST) begin
            next_r.rxsh = word;
            next_r.rxn = r.rxn + 1'b1;
            if (r.rxn == nbits - 1'b1) begin
              if (!async_mode) begin
                fin = 1'b1;
                next_r.rxs = uart_rx_pkg::RX_IDLE;
              end else begin
                // early decision only without check or mode-1 filter
                fin = !r.fee && !(filt && !r.mode[1]);
                ninth = word[8];
                next_r.rxs = uart_rx_pkg::RX_STOP;
              end
            end
          end
        end
      end
      uart_rx_pkg::RX_STOP: begin
        if (rx_tick) begin
          next_r.rxt = r.rxt + 1'b1;
          if (r.rxt == uart_rx_pkg::SAMPLE_LAST) begin
            next_r.rxs = uart_rx_pkg::RX_IDLE;
            // decision at the stop bit
            fin = r.fee || (filt && !r.mode[1]);
            ninth = r.mode[1] ? r.rxsh[8] : rx_level;
            if (r.fee && !rx_level) begin
              next_r.fe = 1'b1;
              next_r.ist[uart_rx_pkg::IRQ_FE_BIT] = 1'b1;
            end
          end
        end
      end
      default: next_r.rxs = uart_rx_pkg::RX_IDLE;
    endcase

    // address recognition on the received byte
    bcast = r.slave_address_reg | r.smask;
    given_hit = ((word[7:0] ^ r.slave_address_reg) & r.smask) == 8'h00;
    bcast_hit = ((word[7:0] ^ bcast) & bcast) == 8'h00;
    if (r.rxs == uart_rx_pkg::RX_STOP) begin
      given_hit = ((r.rxsh[7:0] ^ r.slave_address_reg) & r.smask) == 8'h00;
      bcast_hit = ((r.rxsh[7:0] ^ bcast) & bcast) == 8'h00;
    end
    // deliver only unfiltered or matching address frames
    accept = fin && !r.ri &&
             (!filt || (ninth && (given_hit || bcast_hit)));
    if (accept) begin
      next_r.rxbuf = (r.rxs == uart_rx_pkg::RX_STOP) ? r.rxsh[7:0]
                                                   : word[7:0];
      if (async_mode && (r.mode[1] ||
                         r.rxs == uart_rx_pkg::RX_STOP)) begin
        next_r.rb8 = ninth;
      end
      next_r.ri = 1'b1;
      next_r.ist[uart_rx_pkg::IRQ_RX_BIT] = 1'b1;
    end

    // transmitter, runs beside the receiver
    if (r.txs == uart_rx_pkg::TX_SEND && tx_tick) begin
      next_r.txt = r.txt + 1'b1;
      if (r.txt == uart_rx_pkg::SAMPLE_LAST) begin
        next_r.txsh = {1'b1, r.txsh[10:1]};
        next_r.txn = r.txn + 1'b1;
        if (r.txn == (r.mode[1] ? uart_rx_pkg::TX_BITS_LONG
                                : uart_rx_pkg::TX_BITS_SHORT) - 1'b1) begin
          next_r.txs = uart_rx_pkg::TX_IDLE;
          next_r.ti = 1'b1;
          next_r.ist[uart_rx_pkg::IRQ_TX_BIT] = 1'b1;
        end
      end
    end
    next_r.txd = (next_r.txs == uart_rx_pkg::TX_SEND) ? next_r.txsh[0]
                                                     : 1'b1;

    // level interrupt from unmasked sticky bits
    next_r.irq = |(next_r.ist & next_r.imask);
  end

  // state register with reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.slave_address_reg <= uart_rx_pkg::ADDR_RESET;
      r.smask <= uart_rx_pkg::MASK_RESET;
      r.rxdiv <= uart_rx_pkg::DIV_RESET[DIV_WIDTH-1:0];
      r.txdiv <= uart_rx_pkg::DIV_RESET[DIV_WIDTH-1:0];
      r.rxs <= uart_rx_pkg::RX_IDLE;
      r.txs <= uart_rx_pkg::TX_IDLE;
      r.txsh <= '1;
      r.txd <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flip-flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign txd = r.txd;
  assign irq = r.irq;
endmodule : uart_rx_frame_error_addr_match

// *** verif/serial_node.sv ***
`timescale 1ns/1ps
// far-side node: sends frames on the shared serial line
module serial_node #(
  parameter int BIT_CLKS = 32
) (
  // clock
  input wire logic pclk,
  // line towards the device
  output logic rxd
);
  // line idles high between frames
  initial rxd = 1'b1;

  // one bit held for a whole bit time
  task automatic put_bit(input logic b);
    rxd <= b;
    repeat (BIT_CLKS) @(posedge pclk);
  endtask : put_bit

  // start, data lsb first, optional ninth bit, stop
  task automatic send_frame(input logic [7:0] data, input logic nine_on,
                            input logic ninth, input logic stop);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) begin
      put_bit(data[i]);
    end
    // without a ninth bit the stop bit stands in its place
    if (nine_on) begin
      put_bit(ninth);
    end
    put_bit(stop);
    rxd <= 1'b1;
  endtask : send_frame
endmodule : serial_node

// *** verif/uart_rx_frame_error_addr_match_asserts.sv ***
`timescale 1ns/1ps
// port-level checks for the receive filter block
module uart_rx_frame_error_addr_match_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // serial line and interrupt
  input wire logic rxd,
  input wire logic txd,
  input wire logic irq
);
  // completed transfer and its kinds
  wire logic acc = psel && penable && pready;
  wire logic wr = acc && pwrite;
  wire logic rd = acc && !pwrite;
  wire logic at_ctrl = paddr == uart_rx_pkg::OFF_SERIAL_CTRL;
  wire logic at_id = paddr == uart_rx_pkg::OFF_SLAVE_ADDR ||
    paddr == uart_rx_pkg::OFF_SLAVE_MASK;
  logic fe_seen; // error flag read back set, not cleared since
  logic tx_used; // transmit buffer written since reset
  logic id_wr; // address or mask written since reset

  // helper state from completed transfers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fe_seen <= 1'b0;
      tx_used <= 1'b0;
      id_wr <= 1'b0;
    end else begin
      if (rd && at_ctrl && prdata[uart_rx_pkg::CTRL_FE_BIT]) begin
        fe_seen <= 1'b1;
      end
      if (wr && at_ctrl && !pwdata[uart_rx_pkg::CTRL_FE_BIT]) begin
        fe_seen <= 1'b0;
      end
      if (wr && paddr == uart_rx_pkg::OFF_TX_BUF) begin
        tx_used <= 1'b1;
      end
      if (wr && at_id) begin
        id_wr <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bus phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence

  property p_ready_next;
    s_setup |=> s_access;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("no answer in the cycle after setup");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held longer than one cycle");
  property p_idle_bus;
    !pready |-> prdata == 32'h00000000 && !pslverr;
  endproperty
  a_idle_bus: assert property (p_idle_bus)
    else $error("read data or error outside access");
  property p_decode;
    acc && paddr[1:0] == 2'h0 |->
      pslverr == (paddr > uart_rx_pkg::OFF_IRQ_MASK);
  endproperty
  a_decode: assert property (p_decode)
    else $error("error response does not follow the map");
  property p_id_reset;
    rd && at_id && !id_wr |-> prdata == 32'h00000000;
  endproperty
  a_id_reset: assert property (p_id_reset)
    else $error("address or mask not zero after reset");
  property p_fe_sticky;
    rd && at_ctrl && fe_seen |-> prdata[uart_rx_pkg::CTRL_FE_BIT];
  endproperty
  a_fe_sticky: assert property (p_fe_sticky)
    else $error("framing flag lost without software clear");
  property p_irq_masked;
    wr && paddr == uart_rx_pkg::OFF_IRQ_MASK && pwdata[2:0] == 3'h0
      |=> ##1 !irq [*2];
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt high with all sources masked");
  property p_tx_start;
    wr && paddr == uart_rx_pkg::OFF_TX_BUF && !tx_used |=> !txd;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("start bit not sent after transmit write");
  property p_tx_quiet;
    !tx_used |-> txd;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet)
    else $error("serial output left idle level unprompted");
  property p_reset_exit;
    $rose(presetn) |-> txd && !pready && !irq;
  endproperty
  a_reset_exit: assert property (p_reset_exit)
    else $error("outputs not at rest after reset");
endmodule : uart_rx_frame_error_addr_match_asserts

// *** verif/tb.sv ***
`timescale 1ns/1ps
// self-checking bench for the receive filter block
module tb;
  // clock, reset and bus drive
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  // design outputs and serial line
  logic [31:0] prdata;
  logic pready, pslverr, rxd, txd, irq;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] rd; // last read data
  logic err; // last error response
  // rows: mode, enables, address, mask, byte, ninth/stop, expected
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] en; // filter enable, frame check enable
    logic [7:0] addr;
    logic [7:0] mask;
    logic [7:0] data;
    logic [1:0] ns; // ninth bit, stop bit
    logic [1:0] ex; // receive flag, framing flag
  } row_type;
  row_type rows [12] = '{
    '{2'h1, 2'h1, 8'h00, 8'h00, 8'h3C, 2'h0, 2'h3},
    '{2'h0, 2'h3, 8'h12, 8'hFF, 8'hFF, 2'h1, 2'h2},
    '{2'h3, 2'h2, 8'h00, 8'h00, 8'h9A, 2'h3, 2'h2},
    '{2'h3, 2'h2, 8'h56, 8'hFC, 8'h57, 2'h3, 2'h2},
    '{2'h3, 2'h2, 8'h56, 8'hFC, 8'h5A, 2'h3, 2'h0},
    '{2'h3, 2'h2, 8'h56, 8'hFC, 8'hFE, 2'h3, 2'h2},
    '{2'h3, 2'h2, 8'h56, 8'hFC, 8'h57, 2'h1, 2'h0},
    '{2'h2, 2'h2, 8'hF1, 8'hFA, 8'hF0, 2'h3, 2'h2},
    '{2'h1, 2'h2, 8'hF1, 8'hFF, 8'hF1, 2'h1, 2'h2},
    '{2'h1, 2'h3, 8'hF1, 8'hFF, 8'hF1, 2'h0, 2'h1},
    '{2'h1, 2'h2, 8'hF1, 8'hFF, 8'hF3, 2'h1, 2'h0},
    '{2'h2, 2'h1, 8'h00, 8'h00, 8'hC3, 2'h0, 2'h3}
  };

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  uart_rx_frame_error_addr_match uart_rx_frame_error_addr_match_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxd, .txd, .irq);
  serial_node #(.BIT_CLKS(32)) serial_node_inst (.pclk, .rxd);

  // verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  // compare one value, count and report
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one apb transfer held until ready, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) begin
      fail_count++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // control word: mode, filter enable, receiver on
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic mp);
    return {24'h000000, m, mp, 1'b1, 4'h0};
  endfunction : ctl

  // main sequence
  initial begin
    row_type r;
    logic [31:0] buf_exp;
    logic [9:0] tx_exp;
    static logic [7:0] roff [6] = '{uart_rx_pkg::OFF_SERIAL_CTRL,
      uart_rx_pkg::OFF_POWER_CTRL, uart_rx_pkg::OFF_SLAVE_ADDR,
      uart_rx_pkg::OFF_SLAVE_MASK, uart_rx_pkg::OFF_RX_DIV,
      uart_rx_pkg::OFF_IRQ_STATUS};
    static logic [31:0] rval [6] = '{32'h0, 32'h0, 32'h0, 32'h0,
      {16'h0000, uart_rx_pkg::DIV_RESET}, 32'h0};
    buf_exp = 32'h00000000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, uart_rx_pkg::OFF_RX_DIV, 32'h1);
    apb(1'b1, uart_rx_pkg::OFF_TX_DIV, 32'h1);
    // table of frames through the address filter
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, uart_rx_pkg::OFF_POWER_CTRL, {31'h0, r.en[0]});
      apb(1'b1, uart_rx_pkg::OFF_SLAVE_ADDR, {24'h0, r.addr});
      apb(1'b1, uart_rx_pkg::OFF_SLAVE_MASK, {24'h0, r.mask});
      apb(1'b1, uart_rx_pkg::OFF_SERIAL_CTRL, ctl(r.mode, r.en[1]));
      if (r.mode != 2'h0) begin
        serial_node_inst.send_frame(r.data, r.mode[1], r.ns[1], r.ns[0]);
      end else begin
        repeat (400) @(posedge pclk);
      end
      repeat (8) @(posedge pclk);
      if (r.ex[1]) buf_exp = {24'h0, r.data};
      apb(1'b0, uart_rx_pkg::OFF_SERIAL_CTRL, 32'h0);
      check("receive flag", {31'h0, r.ex[1]}, {31'h0, rd[0]});
      check("framing flag", {31'h0, r.ex[0]}, {31'h0, rd[8]});
      apb(1'b0, uart_rx_pkg::OFF_RX_BUF, 32'h0);
      check("receive buffer", buf_exp, rd);
      apb(1'b1, uart_rx_pkg::OFF_SERIAL_CTRL, 32'h0);
      $display("row %0d done", i);
    end
    // reset in mid-run; six registers are read back at their reset values
    apb(1'b1, uart_rx_pkg::OFF_SLAVE_ADDR, 32'hA5);
    apb(1'b1, uart_rx_pkg::OFF_SLAVE_MASK, 32'h5A);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (roff[i]) begin
      apb(1'b0, roff[i], 32'h0);
      check("reset value", rval[i], rd);
    end
    apb(1'b0, 8'h30, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    $display("reset and map test done");
    apb(1'b1, uart_rx_pkg::OFF_RX_DIV, 32'h1);
    apb(1'b1, uart_rx_pkg::OFF_TX_DIV, 32'h1);
    // receive flag timing seen on the interrupt line
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, uart_rx_pkg::OFF_IRQ_STATUS, 32'h7);
      apb(1'b1, uart_rx_pkg::OFF_IRQ_MASK, 32'h1);
      apb(1'b1, uart_rx_pkg::OFF_POWER_CTRL, {31'h0, f[0]});
      apb(1'b1, uart_rx_pkg::OFF_SERIAL_CTRL, ctl(2'h1, 1'b0));
      fork
        serial_node_inst.send_frame(8'h81, 1'b0, 1'b0, 1'b1);
      join_none
      repeat (290) @(posedge pclk);
      check("irq before stop", {31'h0, f == 0}, {31'h0, irq});
      wait fork;
      repeat (8) @(posedge pclk);
      check("irq after stop", 32'h1, {31'h0, irq});
      apb(1'b1, uart_rx_pkg::OFF_IRQ_MASK, 32'h0);
      check("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, uart_rx_pkg::OFF_IRQ_STATUS, 32'h1);
      apb(1'b1, uart_rx_pkg::OFF_IRQ_MASK, 32'h1);
      check("irq cleared", 32'h0, {31'h0, irq});
      apb(1'b1, uart_rx_pkg::OFF_SERIAL_CTRL, 32'h0);
    end
    $display("flag timing and interrupt test done");
    // framing flag survives good frames until software clears it
    apb(1'b1, uart_rx_pkg::OFF_SERIAL_CTRL, ctl(2'h1, 1'b0));
    serial_node_inst.send_frame(8'h11, 1'b0, 1'b0, 1'b0);
    repeat (8) @(posedge pclk);
    apb(1'b0, uart_rx_pkg::OFF_SERIAL_CTRL, 32'h0);
    check("error set", 32'h1, {31'h0, rd[8]});
    apb(1'b1, uart_rx_pkg::OFF_SERIAL_CTRL, ctl(2'h1, 1'b0) | 32'h100);
    serial_node_inst.send_frame(8'h22, 1'b0, 1'b0, 1'b1);
    repeat (8) @(posedge pclk);
    apb(1'b0, uart_rx_pkg::OFF_SERIAL_CTRL, 32'h0);
    check("error kept", 32'h1, {31'h0, rd[8]});
    apb(1'b1, uart_rx_pkg::OFF_SERIAL_CTRL, ctl(2'h1, 1'b0));
    apb(1'b0, uart_rx_pkg::OFF_SERIAL_CTRL, 32'h0);
    check("error cleared", 32'h0, {31'h0, rd[8]});
    $display("sticky error test done");
    // send while receiving
    apb(1'b1, uart_rx_pkg::OFF_SERIAL_CTRL, ctl(2'h1, 1'b0));
    fork
      serial_node_inst.send_frame(8'h5C, 1'b0, 1'b0, 1'b1);
    join_none
    apb(1'b1, uart_rx_pkg::OFF_TX_BUF, 32'h96);
    tx_exp = {1'b1, 8'h96, 1'b0};
    repeat (15) @(posedge pclk);
    for (int k = 0; k < 10; k++) begin
      check("sent bit", {31'h0, tx_exp[k]}, {31'h0, txd});
      repeat (32) @(posedge pclk);
    end
    wait fork;
    repeat (8) @(posedge pclk);
    apb(1'b0, uart_rx_pkg::OFF_RX_BUF, 32'h0);
    check("received while sending", 32'h5C, rd);
    $display("full duplex test done");
    test_done();
  end
endmodule : tb

bind uart_rx_frame_error_addr_match uart_rx_frame_error_addr_match_asserts
  checker_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .rxd, .txd, .irq);
